// File: dcs_bw_gate.sv
/*
 * Bandwidth gate: within every window of bus clocks, lets the channel use
 * at most (code+1) quanta of clocks.
 * Assumes busy_i comes from logic on the same clock.
 */
`timescale 1ns/10ps
module dcs_bw_gate
   import dcs_pkg::*;
#(
   parameter int WINDOW = BW_WINDOW,
   parameter int QUANTUM = BW_QUANTUM
) (
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // share control
   input wire logic [1:0] share_i,
   input wire logic busy_i,
   output logic allow_o
);
   logic [$clog2(WINDOW):0] win_cnt;
   logic [$clog2(WINDOW):0] used_cnt;
   logic [$clog2(WINDOW):0] limit;

   assign limit = ($clog2(WINDOW)+1)'(QUANTUM) * ($clog2(WINDOW)+1)'({1'b0, share_i} + 3'h1);
   assign allow_o = (used_cnt < limit);

   always_ff @(posedge clk_i) begin
      if (rst_i || win_cnt == ($clog2(WINDOW)+1)'(WINDOW - 1)) begin
         win_cnt <= '0;
      end else begin
         win_cnt <= win_cnt + 1'b1;
      end
   end

   // usage restarts with each window
   always_ff @(posedge clk_i) begin
      if (rst_i || win_cnt == ($clog2(WINDOW)+1)'(WINDOW - 1)) begin
         used_cnt <= '0;
      end else if (busy_i) begin
         used_cnt <= used_cnt + 1'b1;
      end
   end
endmodule

// File: dcs_channel.sv
/*
 * One channel's control, status and destination-address logic, with the
 * byte counter and source pointer it needs, a bus-cycle request port and
 * the peripheral request/acknowledge/end handshake.
 * Assumes a classic Wishbone master on the same clock and a bus that
 * answers each cycle request with xfer_done_i or xfer_berr_i.
 */
// The register offsets and register access over Wishbone were left to the implementer.
`timescale 1ns/10ps

// Overview of operation
// - Internal requests ignore the handshake direction option.
// - Single address, external: option picks read-from-memory or write-to-memory.
// - Dual address, external: option picks source or destination as requester.
// - Source pointer steps by source size when enabled, else fixed.
// - Destination steps by size when enabled, else stays constant.
// - Source size bits 9:8: long, byte, word, unused.
// - Destination size bits 7:6: long, byte, word, unused.
// - Request bits 5:4: internal, reserved, external burst, cycle steal.
// - Internal mode limited to 256..1024 clocks of every 1024.
// - Single address skips holding register; dual runs read then write.
// - Go clears on reset, written zero, or any terminating flag.
// - Go cannot be set while summary flag is set.
// - Internal mode starts on go, stops when go cleared.
// - External mode go only arms; peripheral request starts transfers.
// - Control changes act at once; halt ends after current cycle.
// - Summary flag is OR of five flags, in status bit 7.
// - Done, read error, write error and breakpoint flags set by events.
// - Flags clear only by writing one or reset.
// - Misaligned addresses or bad/zero count at start raise setup error; code checks address bit 0 only, so a long address with bit 1 set passes.
// - Writing 7C to status clears all five flags.
// - Destination wraps unsigned, steps 1/2/4; misaligned raises setup error; code checks only bit 0, even for long.
// - Destination reads give next address, held across a bus error.
// - Count reaching zero sets done; external mode also pulses end line.
// - Go with zero count sets setup error and leaves go clear.
module dcs_channel
   import dcs_pkg::*;
#(
   parameter int BW_WIN = BW_WINDOW
) (
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // wishbone slave
   input wire logic cyc_i,
   input wire logic stb_i,
   input wire logic we_i,
   input wire logic [7:0] adr_i,
   input wire logic [3:0] sel_i,
   input wire logic [31:0] dat_i,
   output logic [31:0] dat_o,
   output logic ack_o,
   // bus cycle request
   output logic xfer_req_o,
   output logic xfer_we_o,
   output logic [31:0] xfer_addr_o,
   output logic [1:0] xfer_size_o,
   output logic xfer_use_hold_o,
   input wire logic xfer_done_i,
   input wire logic xfer_berr_i,
   input wire logic brk_i,
   // peripheral handshake
   input wire logic transfer_request_in_n_i,
   output logic transfer_ack_out_n_o,
   output logic transfer_end_line_n_o
);
   typedef enum logic [1:0] {S_IDLE, S_READ, S_WRITE} dcs_state_e;

   dcs_state_e state, next_state;
   logic [15:0] channel_control;
   logic channel_go;
   logic [ST_NFLAGS-1:0] flags;
   logic [ST_NFLAGS-1:0] flag_set;
   logic [31:0] destination_address, source_pointer, byte_counter;
   logic req_meta, req_sync, steal_hold, end_pulse;
   logic bus_acc, wr_fire, irq;
   logic [15:0] new_ctl;
   logic [2:0] ssz_b, dsz_b, max_b, new_sb, new_db, new_mb;
   logic cfg_bad, go_write, cycle_end, op_end, op_step, can_go, bw_allow;
   logic ext_mode, int_mode, handshake_direction_option, single, hs_phase;
   logic [31:0] next_count;

   // ------------------------------------------------------------------
   // field decode
   // ------------------------------------------------------------------
   assign ext_mode = channel_control[CC_REQ_LO+1];
   assign int_mode = channel_control[CC_REQ_LO+:2] == REQ_INT;
   // option only counts with external requests
   assign handshake_direction_option = channel_control[CC_ECO] & ext_mode;
   assign single = channel_control[CC_SINGLE];
   assign ssz_b = size_bytes(channel_control[CC_SOURCE_SIZE_FIELD_LO+:2]);
   assign dsz_b = size_bytes(channel_control[CC_DEST_SIZE_FIELD_LO+:2]);
   assign max_b = (ssz_b > dsz_b) ? ssz_b : dsz_b;
   assign irq = |flags;

   // ------------------------------------------------------------------
   // wishbone slave: ack one cycle after request, writes act on ack edge
   // ------------------------------------------------------------------
   assign bus_acc = cyc_i & stb_i & ~ack_o;
   assign wr_fire = cyc_i & stb_i & we_i & ack_o;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_o <= 1'b0;
      end else begin
         ack_o <= bus_acc;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         dat_o <= '0;
      end else if (bus_acc) begin
         unique case (adr_i)
            ADR_CONTROL: dat_o <= {16'h0000, channel_control[15:1], channel_go};
            ADR_STATUS: dat_o <= {24'h000000, irq, flags, 2'h0};
            ADR_DEST: dat_o <= destination_address;
            ADR_COUNT: dat_o <= byte_counter;
            ADR_SOURCE: dat_o <= source_pointer;
            default: dat_o <= '0;
         endcase
      end
   end

   // ------------------------------------------------------------------
   // control register and go bit
   // ------------------------------------------------------------------
   always_comb begin
      new_ctl = channel_control;
      if (sel_i[0]) begin
         new_ctl[7:0] = dat_i[7:0];
      end
      if (sel_i[1]) begin
         new_ctl[15:8] = dat_i[15:8];
      end
      new_ctl = new_ctl & CC_WMASK;
   end

   assign new_sb = size_bytes(new_ctl[CC_SOURCE_SIZE_FIELD_LO+:2]);
   assign new_db = size_bytes(new_ctl[CC_DEST_SIZE_FIELD_LO+:2]);
   assign new_mb = (new_sb > new_db) ? new_sb : new_db;

   // setup check on the values being started with
   always_comb begin
      cfg_bad = (new_sb == 3'h0) || (new_db == 3'h0) || (byte_counter == 32'h0);
      if (new_sb != 3'h1 && source_pointer[0]) begin
         cfg_bad = 1'b1;
      end
      if (new_db != 3'h1 && destination_address[0]) begin
         cfg_bad = 1'b1;
      end
      if ((new_mb == 3'h2 && byte_counter[0]) || (new_mb == 3'h4 && |byte_counter[1:0])) begin
         cfg_bad = 1'b1;
      end
   end

   assign go_write = wr_fire && adr_i == ADR_CONTROL && sel_i[0] && dat_i[CC_GO];

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         channel_control <= CC_RESET;
      end else if (wr_fire && adr_i == ADR_CONTROL) begin
         channel_control <= new_ctl;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         channel_go <= 1'b0;
      end else if (|flag_set) begin
         channel_go <= 1'b0;
      end else if (wr_fire && adr_i == ADR_CONTROL && sel_i[0]) begin
         channel_go <= dat_i[CC_GO] & ~irq & ~cfg_bad;
      end
   end

   // ------------------------------------------------------------------
   // status flags: hardware set wins over software clear
   // ------------------------------------------------------------------
   // event sources
   always_comb begin
      flag_set = '0;
      flag_set[ST_SETUP-2] = go_write & ~irq & cfg_bad;
      flag_set[ST_RDERR-2] = state == S_READ && xfer_berr_i;
      flag_set[ST_WRERR-2] = state == S_WRITE && xfer_berr_i;
      flag_set[ST_BRK-2] = state != S_IDLE && brk_i;
      flag_set[ST_DONE-2] = op_end && next_count == 32'h0;
   end

   genvar gi;
   generate
      for (gi = 0; gi < ST_NFLAGS; gi++) begin : g_flag
         always_ff @(posedge clk_i) begin
            if (rst_i) begin
               flags[gi] <= 1'b0;
            end else if (flag_set[gi]) begin
               flags[gi] <= 1'b1;
            end else if (wr_fire && adr_i == ADR_STATUS && sel_i[0] && dat_i[gi+2]) begin
               flags[gi] <= 1'b0;
            end
         end
      end
   endgenerate

   // ------------------------------------------------------------------
   // request pin and pacing
   // ------------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         req_meta <= 1'b0;
         req_sync <= 1'b0;
      end else begin
         req_meta <= ~transfer_request_in_n_i;
         req_sync <= req_meta;
      end
   end

   // cycle steal: one operand per request, then wait for release
   always_ff @(posedge clk_i) begin
      if (rst_i || !req_sync) begin
         steal_hold <= 1'b0;
      end else if (op_end && channel_control[CC_REQ_LO+:2] == REQ_STEAL) begin
         steal_hold <= 1'b1;
      end
   end

   dcs_bw_gate #(
      .WINDOW(BW_WIN),
      .QUANTUM(BW_WIN / 4)
   ) u_bw (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .share_i(channel_control[CC_BW_LO+:2]),
      .busy_i(xfer_req_o),
      .allow_o(bw_allow)
   );

   // internal starts at once, external waits for request
   assign can_go = channel_go && !irq && (int_mode ? bw_allow :
                   (ext_mode && req_sync && !steal_hold));

   // ------------------------------------------------------------------
   // transfer sequencer
   // ------------------------------------------------------------------
   assign cycle_end = xfer_done_i | xfer_berr_i;
   // operand complete: last bus cycle of the operand ends cleanly
   assign op_end = xfer_done_i && !xfer_berr_i &&
                   (state == S_WRITE || (state == S_READ && single));
   // last cycle of an operand ended, cleanly or with a bus error
   assign op_step = cycle_end && (state == S_WRITE || (state == S_READ && single));
   assign next_count = byte_counter - {29'h0, max_b};

   always_comb begin
      next_state = state;
      unique case (state)
         S_IDLE: begin
            if (can_go) begin
               // single address is one cycle, option gives direction
               next_state = (single && !handshake_direction_option) ? S_WRITE : S_READ;
            end
         end
         S_READ: begin
            if (cycle_end) begin
               // a cleared go halts at the end of this cycle
               next_state = (single || xfer_berr_i || !channel_go || brk_i) ? S_IDLE : S_WRITE;
            end
         end
         S_WRITE: begin
            if (cycle_end) begin
               next_state = S_IDLE;
            end
         end
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         state <= S_IDLE;
      end else begin
         state <= next_state;
      end
   end

   assign xfer_req_o = state != S_IDLE;
   assign xfer_we_o = state == S_WRITE;
   assign xfer_use_hold_o = ~single;
   assign xfer_addr_o = (state == S_WRITE) ? destination_address : source_pointer;
   assign xfer_size_o = (state == S_WRITE) ? channel_control[CC_DEST_SIZE_FIELD_LO+:2]
                                           : channel_control[CC_SOURCE_SIZE_FIELD_LO+:2];

   // acknowledge in the read portion if option set, else write
   assign hs_phase = handshake_direction_option ? (state == S_READ) : (state == S_WRITE);
   assign transfer_ack_out_n_o = ~(ext_mode && hs_phase);

   // ------------------------------------------------------------------
   // address and count registers; software writes win over stepping
   // ------------------------------------------------------------------
   // step after every operand, so an error still reads as the next address
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         destination_address <= '0;
      end else if (wr_fire && adr_i == ADR_DEST) begin
         for (int b = 0; b < 4; b++) begin
            if (sel_i[b]) begin
               destination_address[b*8+:8] <= dat_i[b*8+:8];
            end
         end
      end else if (op_step && channel_control[CC_DINC]) begin
         destination_address <= destination_address + {29'h0, dsz_b};
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         source_pointer <= '0;
      end else if (wr_fire && adr_i == ADR_SOURCE) begin
         for (int b = 0; b < 4; b++) begin
            if (sel_i[b]) begin
               source_pointer[b*8+:8] <= dat_i[b*8+:8];
            end
         end
      end else if (op_end && channel_control[CC_SINC]) begin
         source_pointer <= source_pointer + {29'h0, ssz_b};
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         byte_counter <= '0;
      end else if (wr_fire && adr_i == ADR_COUNT) begin
         for (int b = 0; b < 4; b++) begin
            if (sel_i[b]) begin
               byte_counter[b*8+:8] <= dat_i[b*8+:8];
            end
         end
      end else if (op_step) begin
         byte_counter <= next_count;
      end
   end

   // end line pulses when the count empties in external mode
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         end_pulse <= 1'b0;
      end else begin
         end_pulse <= op_end && next_count == 32'h0 && ext_mode;
      end
   end
   assign transfer_end_line_n_o = ~end_pulse;

   // ------------------------------------------------------------------
   // assertions
   // ------------------------------------------------------------------
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   sequence s_dest_write_ok;
      state == S_WRITE && xfer_done_i && !xfer_berr_i && !wr_fire;
   endsequence

   property p_int_no_eco;
      state == S_IDLE && int_mode && single && can_go |=> state == S_WRITE;
   endproperty
   a_int_no_eco: assert property (p_int_no_eco) else $error("option used in internal mode");

   property p_dual_read_first;
      state == S_IDLE && can_go && !single |=> state == S_READ;
   endproperty
   a_dual_read_first: assert property (p_dual_read_first) else $error("dual did not read");

   property p_go_refused;
      go_write && irq && !channel_go |=> !channel_go;
   endproperty
   a_go_refused: assert property (p_go_refused) else $error("go set while flagged");

   property p_flag_drops_go;
      |flag_set |=> !channel_go && irq;
   endproperty
   a_flag_drops_go: assert property (p_flag_drops_go) else $error("go kept after flag");

   property p_clear_all;
      wr_fire && adr_i == ADR_STATUS && sel_i[0] && dat_i[7:0] == ST_CLEAR_ALL && flag_set == '0
         |=> flags == '0 && !irq;
   endproperty
   a_clear_all: assert property (p_clear_all) else $error("flags not cleared");

   property p_zero_keeps;
      wr_fire && adr_i == ADR_STATUS && dat_i[ST_DONE] == 1'b0 && flags[ST_DONE-2]
         |=> flags[ST_DONE-2];
   endproperty
   a_zero_keeps: assert property (p_zero_keeps) else $error("done lost on zero write");

   property p_dest_byte_step;
      s_dest_write_ok ##0 (channel_control[CC_DINC] && dsz_b == 3'h1)
         |=> destination_address == $past(destination_address) + 32'h1;
   endproperty
   a_dest_byte_step: assert property (p_dest_byte_step) else $error("dest step wrong");

   property p_berr_hold;
      xfer_berr_i && state == S_WRITE && !wr_fire && channel_control[CC_DINC] && dsz_b == 3'h1
         |=> destination_address == $past(destination_address) + 32'h1;
   endproperty
   a_berr_hold: assert property (p_berr_hold) else $error("dest not stepped on error");

   property p_ext_waits;
      state == S_IDLE && ext_mode && !req_sync |=> state == S_IDLE;
   endproperty
   a_ext_waits: assert property (p_ext_waits) else $error("started without request");

   property p_done_end;
      op_end && next_count == 32'h0 && ext_mode |=> !transfer_end_line_n_o && flags[ST_DONE-2];
   endproperty
   a_done_end: assert property (p_done_end) else $error("end line missing");
endmodule

// File: dcs_periph.sv
/*
 * Far-side partner of the channel: answers bus cycle requests slowly and
 * paces external transfers through the active-low request line.
 * Assumes the same clock as the channel; the bench commands errors.
 */
`timescale 1ns/10ps
module dcs_periph (
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // commands from the bench
   input wire logic req_en_i,
   input wire logic berr_wr_i,
   // bus cycle port
   input wire logic xfer_req_i,
   input wire logic xfer_we_i,
   output logic xfer_done_o,
   output logic xfer_berr_o,
   // handshake and tallies
   output logic request_n_o,
   input wire logic ack_n_i,
   input wire logic end_n_i,
   output logic [7:0] ack_rd_o,
   output logic [7:0] ack_wr_o,
   output logic [7:0] end_cnt_o
);
   logic [1:0] wait_cnt;

   // request held until bench drops it
   always_ff @(posedge clk_i) begin
      request_n_o <= rst_i | ~req_en_i;
   end

   // slow answer: a few clocks per bus cycle, never twice in a row
   always_ff @(posedge clk_i) begin
      xfer_done_o <= 1'b0;
      xfer_berr_o <= 1'b0;
      if (rst_i || !xfer_req_i || xfer_done_o || xfer_berr_o) begin
         wait_cnt <= 2'h0;
      end else if (wait_cnt == 2'h2) begin
         xfer_berr_o <= berr_wr_i & xfer_we_i;
         xfer_done_o <= ~(berr_wr_i & xfer_we_i);
      end else begin
         wait_cnt <= wait_cnt + 2'h1;
      end
   end

   // tally which portion carries the acknowledge
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_rd_o <= 8'h00;
         ack_wr_o <= 8'h00;
         end_cnt_o <= 8'h00;
      end else begin
         if (xfer_done_o && !ack_n_i && xfer_we_i) begin
            ack_wr_o <= ack_wr_o + 8'h01;
         end
         if (xfer_done_o && !ack_n_i && !xfer_we_i) begin
            ack_rd_o <= ack_rd_o + 8'h01;
         end
         if (!end_n_i) begin
            end_cnt_o <= end_cnt_o + 8'h01;
         end
      end
   end
endmodule

// File: dcs_pkg.sv
/*
 * Shared constants for the channel control/status block: register offsets,
 * control field positions, status bit positions, size and request codes.
 * Assumes a 32-bit classic Wishbone register bus with byte addresses.
 */
package dcs_pkg;

   // ------------------------------------------------------------------
   // register offsets (byte addresses)
   // ------------------------------------------------------------------
   localparam logic [7:0] ADR_CONTROL = 8'h00;
   localparam logic [7:0] ADR_STATUS = 8'h04;
   localparam logic [7:0] ADR_DEST = 8'h08;
   localparam logic [7:0] ADR_COUNT = 8'h0C;
   localparam logic [7:0] ADR_SOURCE = 8'h10;

   // ------------------------------------------------------------------
   // channel_control fields
   // ------------------------------------------------------------------
   localparam int CC_GO = 0;
   localparam int CC_SINGLE = 1;
   localparam int CC_BW_LO = 2;
   localparam int CC_REQ_LO = 4;
   localparam int CC_DEST_SIZE_FIELD_LO = 6;
   localparam int CC_SOURCE_SIZE_FIELD_LO = 8;
   localparam int CC_DINC = 10;
   localparam int CC_SINC = 11;
   localparam int CC_ECO = 12;
   localparam logic [15:0] CC_WMASK = 16'h1FFE;
   localparam logic [15:0] CC_RESET = 16'h0000;

   // ------------------------------------------------------------------
   // channel_status bits
   // ------------------------------------------------------------------
   localparam int ST_BRK = 2;
   localparam int ST_SETUP = 3;
   localparam int ST_WRERR = 4;
   localparam int ST_RDERR = 5;
   localparam int ST_DONE = 6;
   localparam int ST_IRQ = 7;
   localparam int ST_NFLAGS = 5;
   localparam logic [7:0] ST_CLEAR_ALL = 8'h7C;

   // ------------------------------------------------------------------
   // codes
   // ------------------------------------------------------------------
   localparam logic [1:0] SZ_LONG = 2'h0;
   localparam logic [1:0] SZ_BYTE = 2'h1;
   localparam logic [1:0] SZ_WORD = 2'h2;
   localparam logic [1:0] REQ_INT = 2'h0;
   localparam logic [1:0] REQ_BURST = 2'h2;
   localparam logic [1:0] REQ_STEAL = 2'h3;
   localparam int BW_WINDOW = 1024;
   localparam int BW_QUANTUM = 256;

   // operand size in bytes; unused code gives zero
   function automatic logic [2:0] size_bytes(input logic [1:0] code);
      case (code)
         SZ_LONG: size_bytes = 3'h4;
         SZ_BYTE: size_bytes = 3'h1;
         SZ_WORD: size_bytes = 3'h2;
         default: size_bytes = 3'h0;
      endcase
   endfunction

endpackage

// File: testbench.sv
/*
 * Register-level bench for the channel: Wishbone read/write tasks and
 * sequences with expected values.
 * Assumes the partner model answers bus cycles and drives the request line.
 */
`timescale 1ns/10ps
module testbench;
   import dcs_pkg::*;
   logic clk_i, rst_i, cyc, stb, we, ack, req_en, berr_wr, brk;
   logic xreq, xwe, xdone, xberr, req_n, ack_n, end_n;
   logic [7:0] adr, ack_rd, ack_wr, end_cnt;
   logic [3:0] sel;
   logic [31:0] dat_w, dat_r, rd;
   int failures = 0, tests_run = 0, cycles = 0;

   dcs_channel #(.BW_WIN(16)) dcs_channel_inst (.clk_i(clk_i), .rst_i(rst_i),
      .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(sel), .dat_i(dat_w),
      .dat_o(dat_r), .ack_o(ack), .xfer_req_o(xreq), .xfer_we_o(xwe), .xfer_addr_o(),
      .xfer_size_o(), .xfer_use_hold_o(), .xfer_done_i(xdone), .xfer_berr_i(xberr),
      .brk_i(brk), .transfer_request_in_n_i(req_n), .transfer_ack_out_n_o(ack_n),
      .transfer_end_line_n_o(end_n));
   dcs_periph dcs_periph_inst (.clk_i(clk_i), .rst_i(rst_i), .req_en_i(req_en),
      .berr_wr_i(berr_wr), .xfer_req_i(xreq), .xfer_we_i(xwe), .xfer_done_o(xdone),
      .xfer_berr_o(xberr), .request_n_o(req_n), .ack_n_i(ack_n), .end_n_i(end_n),
      .ack_rd_o(ack_rd), .ack_wr_o(ack_wr), .end_cnt_o(end_cnt));

   initial begin
      clk_i = 1'b0;
      forever #5 clk_i = ~clk_i;
   end

   task results;
      if (failures == 0 && tests_run > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask

   // hang guard: whole sequence needs a few hundred clocks
   always @(posedge clk_i) begin
      cycles = cycles + 1;
      if (cycles == 20000) begin
         failures = failures + 1;
         results();
      end
   end

   task chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
      tests_run = tests_run + 1;
      if (seen !== exp) begin
         failures = failures + 1;
         $display("[FAIL] %s expected %h seen %h", name, exp, seen);
      end
   endtask

   // called just after a rising edge; request held until ack is seen at an edge
   task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      dat_w <= d;
      do @(posedge clk_i); while (ack !== 1'b1);
      rd = dat_r;
      cyc <= 1'b0;
      stb <= 1'b0;
      @(posedge clk_i);
   endtask

   task rdchk(input string name, input logic [7:0] a, input logic [31:0] exp);
      repeat (3) @(posedge clk_i);
      wb(1'b0, a, 32'h0);
      chk(name, rd, exp);
   endtask

   task run(input logic [31:0] dst, input logic [31:0] cnt, input logic [31:0] ctl);
      wb(1'b1, ADR_DEST, dst);
      wb(1'b1, ADR_SOURCE, 32'h40);
      wb(1'b1, ADR_COUNT, cnt);
      wb(1'b1, ADR_CONTROL, ctl);
   endtask

   task wait_flag;
      int n;
      n = 0;
      do begin
         wb(1'b0, ADR_STATUS, 32'h0);
         n = n + 1;
      end while (rd[7] !== 1'b1 && n < 200);
      chk("flag wait", {31'h0, rd[7]}, 32'h1);
   endtask

   initial begin
      {cyc, stb, we, req_en, berr_wr, brk} = 6'h00;
      rst_i = 1'b1;
      adr = 8'h00;
      sel = 4'hF;
      dat_w = 32'h0;
      repeat (8) @(posedge clk_i);
      rst_i <= 1'b0;
      rdchk("control", ADR_CONTROL, 32'h0);
      rdchk("status", ADR_STATUS, 32'h0);
      // go with zero count
      wb(1'b1, ADR_CONTROL, 32'h0D4D);
      rdchk("status", ADR_STATUS, 32'h88);
      rdchk("control", ADR_CONTROL, 32'h0D4C);
      wb(1'b1, ADR_COUNT, 32'h4);
      wb(1'b1, ADR_CONTROL, 32'h0D4D);
      rdchk("control", ADR_CONTROL, 32'h0D4C);
      wb(1'b1, ADR_STATUS, 32'h0);
      rdchk("status", ADR_STATUS, 32'h88);
      wb(1'b1, ADR_STATUS, 32'h7C);
      rdchk("status", ADR_STATUS, 32'h0);
      // internal byte run, both pointers stepping; done survives a zero write
      run(32'h100, 32'h4, 32'h0D4D);
      wait_flag();
      wb(1'b1, ADR_STATUS, 32'h3C);
      rdchk("status", ADR_STATUS, 32'hC0);
      rdchk("dest", ADR_DEST, 32'h104);
      rdchk("source", ADR_SOURCE, 32'h44);
      rdchk("count", ADR_COUNT, 32'h0);
      rdchk("control", ADR_CONTROL, 32'h0D4C);
      wb(1'b1, ADR_STATUS, 32'h7C);
      // write-cycle bus error
      berr_wr <= 1'b1;
      run(32'h200, 32'h4, 32'h0D4D);
      wait_flag();
      berr_wr <= 1'b0;
      rdchk("status", ADR_STATUS, 32'h90);
      rdchk("dest", ADR_DEST, 32'h201);
      rdchk("count", ADR_COUNT, 32'h3);
      wb(1'b1, ADR_STATUS, 32'h7C);
      // breakpoint during an internal run
      brk <= 1'b1;
      run(32'h100, 32'h4, 32'h0D4D);
      wait_flag();
      brk <= 1'b0;
      rdchk("status", ADR_STATUS, 32'h84);
      rdchk("control", ADR_CONTROL, 32'h0D4C);
      wb(1'b1, ADR_STATUS, 32'h7C);
      // misaligned word destination
      run(32'h101, 32'h2, 32'h0E8D);
      rdchk("status", ADR_STATUS, 32'h88);
      rdchk("control", ADR_CONTROL, 32'h0E8C);
      wb(1'b1, ADR_STATUS, 32'h7C);
      // halt by clearing go mid-run: the first read ends, its write never runs
      run(32'h400, 32'h40, 32'h0D4D);
      wb(1'b1, ADR_CONTROL, 32'h0D4C);
      rdchk("status", ADR_STATUS, 32'h0);
      rdchk("count left", ADR_COUNT, 32'h40);
      // external burst, single address, write portion handshake
      run(32'h300, 32'h2, 32'h0563);
      rdchk("status", ADR_STATUS, 32'h0);
      rdchk("control", ADR_CONTROL, 32'h0563);
      req_en <= 1'b1;
      wait_flag();
      req_en <= 1'b0;
      rdchk("status", ADR_STATUS, 32'hC0);
      rdchk("dest", ADR_DEST, 32'h302);
      wb(1'b1, ADR_STATUS, 32'h7C);
      // internal single address with the option set: option ignored, no handshake
      run(32'h500, 32'h1, 32'h1D4F);
      wait_flag();
      rdchk("status", ADR_STATUS, 32'hC0);
      rdchk("dest", ADR_DEST, 32'h501);
      wb(1'b1, ADR_STATUS, 32'h7C);
      // external single address with the option set: read portion handshake
      run(32'h600, 32'h1, 32'h1563);
      req_en <= 1'b1;
      wait_flag();
      req_en <= 1'b0;
      rdchk("status", ADR_STATUS, 32'hC0);
      rdchk("dest", ADR_DEST, 32'h601);
      chk("ack write", {24'h0, ack_wr}, 32'h2);
      chk("ack read", {24'h0, ack_rd}, 32'h1);
      chk("end line", {24'h0, end_cnt}, 32'h2);
      results();
   end
endmodule
